// ==== csh_defines.svh ====
// Purpose: shared constants for the snoop, flush and bus-hold controller
// Assumes: 32-byte lines, four 64-bit beats per line
// Notes:   included by bare name
`ifndef CSH_DEFINES_SVH
`define CSH_DEFINES_SVH

// ----------------------------------------------------------------------
// line geometry
// ----------------------------------------------------------------------
`define CSH_LINE_W        27
`define CSH_L1_IDX_W      7
`define CSH_L2_IDX_W      9
`define CSH_BEAT_FIRST    2'h0
`define CSH_BEAT_STEP     2'h1
`define CSH_BEAT_LAST     2'h3

// ----------------------------------------------------------------------
// bus cycle encodings
// ----------------------------------------------------------------------
`define CSH_BLE_ALL       8'h00
`define CSH_BLE_NONE      8'hff
`define CSH_FLUSH_ACK_BE  8'hef
`define CSH_ADDR_ZERO     29'h0
`define CSH_DATA_ZERO     64'h0

`endif

// ==== csh_pkg.sv ====
// Purpose: types for the snoop, flush and bus-hold controller
// Assumes: nothing
// Notes:   constants live in csh_defines.svh
package csh_pkg;

  // --------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    LINE_INV,
    LINE_SHR,
    LINE_EXC,
    LINE_MOD
  } csh_line_e;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_SCAN,
    ST_WB_LOAD,
    ST_WB_BEAT,
    ST_INV,
    ST_ACK_ADDR,
    ST_ACK_WAIT,
    ST_FLOAT,
    ST_HELD
  } csh_state_e;

endpackage : csh_pkg

// ==== csh_tag_if.sv ====
// Purpose: lookup, update and scan path between controller and tag store
// Assumes: one instance per cache level
// Notes:   update acts on the line named by lk_line
`timescale 1ns/1ns
`include "csh_defines.svh"
interface csh_tag_if
#(
  parameter int IDX_W = `CSH_L1_IDX_W
);
  import csh_pkg::*;

  logic [`CSH_LINE_W-1:0] lk_line;
  logic                   lk_hit;
  logic                   lk_dirty;
  logic                   upd;
  csh_line_e              upd_state;
  logic                   fill;
  logic [`CSH_LINE_W-1:0] fill_line;
  csh_line_e              fill_state;
  logic                   inv_all;
  logic [IDX_W-1:0]       scan_idx;
  logic                   scan_dirty;
  logic [`CSH_LINE_W-1:0] scan_line;

  modport ctl (
    output lk_line, upd, upd_state, fill, fill_line, fill_state,
    output inv_all, scan_idx,
    input  lk_hit, lk_dirty, scan_dirty, scan_line
  );

  modport store (
    input  lk_line, upd, upd_state, fill, fill_line, fill_state,
    input  inv_all, scan_idx,
    output lk_hit, lk_dirty, scan_dirty, scan_line
  );

endinterface : csh_tag_if

// ==== csh_strap_catch.sv ====
// Purpose: catch the flush strap at reset release, detect flush requests
// Assumes: flush_n_i synchronous to mclk_i
// Notes:   strap taken on the first edge after release
`timescale 1ns/1ns
module csh_strap_catch
(
  input  wire logic mclk_i,
  input  wire logic resetn_i,
  input  wire logic flush_n_i,
  output logic      armed_o,
  output logic      test_mode_o,
  output logic      flush_req_o
);

  logic prev_n;

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      armed_o <= 1'b0;
    else
      armed_o <= 1'b1;
  end

  // strap sampled once, clocked, never under reset
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      test_mode_o <= 1'b0;
    else if (!armed_o)
      test_mode_o <= ~flush_n_i;
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      prev_n <= 1'b1;
    else
      prev_n <= flush_n_i;
  end

  // falling edge only, so a held request flushes once
  assign flush_req_o = armed_o && prev_n && !flush_n_i;

endmodule : csh_strap_catch

// ==== csh_tag_store.sv ====
// Purpose: direct-mapped line state and tags for one cache level
// Assumes: core fills lines through the fill port
// Notes:   lookup and scan are combinational
`timescale 1ns/1ns
`include "csh_defines.svh"
module csh_tag_store
  import csh_pkg::*;
#(
  parameter int IDX_W = `CSH_L1_IDX_W
)
(
  input  wire logic mclk_i,
  input  wire logic resetn_i,
  csh_tag_if.store  tag
);

  localparam int LINES = 1 << IDX_W;
  localparam int TAG_W = `CSH_LINE_W - IDX_W;

  logic [TAG_W-1:0] tag_q [LINES];
  csh_line_e        st_q  [LINES];
  logic [IDX_W-1:0] lk_idx;
  logic [IDX_W-1:0] fill_idx;

  function automatic logic [IDX_W-1:0] idx_of(
    input logic [`CSH_LINE_W-1:0] line
  );
    return line[IDX_W-1:0];
  endfunction : idx_of

  function automatic logic [TAG_W-1:0] tag_of(
    input logic [`CSH_LINE_W-1:0] line
  );
    return line[`CSH_LINE_W-1:IDX_W];
  endfunction : tag_of

  assign lk_idx         = idx_of(tag.lk_line);
  assign fill_idx       = idx_of(tag.fill_line);
  assign tag.lk_hit     = (st_q[lk_idx] != LINE_INV) &&
                          (tag_q[lk_idx] == tag_of(tag.lk_line));
  assign tag.lk_dirty   = tag.lk_hit && (st_q[lk_idx] == LINE_MOD);
  assign tag.scan_dirty = (st_q[tag.scan_idx] == LINE_MOD);
  assign tag.scan_line  = {tag_q[tag.scan_idx], tag.scan_idx};

  // ----------------------------------------------------------------------
  // line state
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      for (int i = 0; i < LINES; i++)
        st_q[i] <= LINE_INV;
    end
    else if (tag.inv_all)
    begin
      for (int i = 0; i < LINES; i++)
        st_q[i] <= LINE_INV;
    end
    else
    begin
      if (tag.upd && tag.lk_hit)
        st_q[lk_idx] <= tag.upd_state;
      // fill last: a new line overrides a snoop on the old one
      if (tag.fill)
        st_q[fill_idx] <= tag.fill_state;
    end
  end

  // tags need no reset, state gates them
  always_ff @(posedge mclk_i)
  begin
    if (tag.fill)
      tag_q[fill_idx] <= tag_of(tag.fill_line);
  end

endmodule : csh_tag_store

// ==== csh_ctrl.sv ====
// Purpose: flush, inquire response, writeback and bus-hold control
// Assumes: all inputs synchronous to mclk_i
// Notes:   pins split into input, output and enable
`timescale 1ns/1ns
`include "csh_defines.svh"
module csh_ctrl
  import csh_pkg::*;
#(
  parameter int L1_IDX_W = `CSH_L1_IDX_W,
  parameter int L2_IDX_W = `CSH_L2_IDX_W
)
(
  input  wire logic                   mclk_i,
  input  wire logic                   resetn_i,
  input  wire logic                   flush_n_i,
  input  wire logic                   snoop_addr_strobe_n_i,
  input  wire logic [31:3]            addr_i,
  input  wire logic                   snoop_kill_line_i,
  input  wire logic                   bus_hold_req_i,
  input  wire logic                   xfer_ready_n_i,
  input  wire logic                   fill_l1_i,
  input  wire logic                   fill_l2_i,
  input  wire logic [`CSH_LINE_W-1:0] fill_line_i,
  input  wire csh_line_e              fill_state_i,
  input  wire logic [63:0]            wb_data_i,
  output logic                        snoop_hit_n_o,
  output logic                        snoop_dirty_match_n_o,
  output logic                        bus_surrender_ack_o,
  output logic                        test_mode_o,
  output logic                        flush_busy_o,
  output logic                        wb_src_l2_o,
  output logic                        bus_oe_o,
  output logic                        data_oe_o,
  output logic [31:3]                 addr_o,
  output logic                        addr_parity_o,
  output logic [7:0]                  byte_lane_en_n_o,
  output logic                        cycle_addr_strobe_n_o,
  output logic                        cycle_addr_strobe_copy_n_o,
  output logic                        mem_io_o,
  output logic                        data_code_o,
  output logic                        write_read_o,
  output logic                        cache_burst_n_o,
  output logic                        lock_n_o,
  output logic                        page_uncached_o,
  output logic                        page_writethrough_o,
  output logic                        split_cycle_o,
  output logic [63:0]                 data_o,
  output logic [7:0]                  data_byte_parity_o
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  csh_state_e             state_q;
  csh_state_e             next_state;
  logic [31:3]            next_addr;
  logic                   armed;
  logic                   flush_req;
  logic                   snoop_pend;
  logic [`CSH_LINE_W-1:0] snoop_line;
  logic                   snoop_go;
  logic                   wb_pend;
  logic [`CSH_LINE_W-1:0] wb_line;
  logic                   wb_l2;
  logic                   wb_is_flush;
  logic                   start_wb;
  logic                   beat_adv;
  logic                   wb_done;
  logic                   ack_done;
  logic [L2_IDX_W-1:0]    scan_idx;
  logic                   scan_lvl;
  logic                   scan_end;
  logic                   scan_adv;
  logic                   scan_last;
  logic                   scan_dirty;
  logic [`CSH_LINE_W-1:0] scan_line;
  logic                   any_hit;
  logic                   any_dirty;
  logic                   floated;

  csh_tag_if #(.IDX_W(L1_IDX_W)) l1_if ();
  csh_tag_if #(.IDX_W(L2_IDX_W)) l2_if ();

  function automatic logic [7:0] byte_par(input logic [63:0] v);
    logic [7:0] p;
    p = 8'h00;
    for (int b = 0; b < 8; b++)
      p[b] = ^v[b*8 +: 8];
    return p;
  endfunction : byte_par

  // ----------------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------------
  csh_strap_catch u_strap (
    .mclk_i      (mclk_i),
    .resetn_i    (resetn_i),
    .flush_n_i   (flush_n_i),
    .armed_o     (armed),
    .test_mode_o (test_mode_o),
    .flush_req_o (flush_req)
  );

  csh_tag_store #(.IDX_W(L1_IDX_W)) u_l1 (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .tag      (l1_if.store)
  );

  csh_tag_store #(.IDX_W(L2_IDX_W)) u_l2 (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .tag      (l2_if.store)
  );

  // ----------------------------------------------------------------------
  // tag store hookup
  // ----------------------------------------------------------------------
  assign l1_if.lk_line    = snoop_line;
  assign l2_if.lk_line    = snoop_line;
  assign l1_if.upd        = snoop_go;
  assign l2_if.upd        = snoop_go;
  assign l1_if.upd_state  = snoop_kill_line_i ? LINE_INV : LINE_SHR;
  assign l2_if.upd_state  = snoop_kill_line_i ? LINE_INV : LINE_SHR;
  assign l1_if.fill       = fill_l1_i;
  assign l2_if.fill       = fill_l2_i;
  assign l1_if.fill_line  = fill_line_i;
  assign l2_if.fill_line  = fill_line_i;
  assign l1_if.fill_state = fill_state_i;
  assign l2_if.fill_state = fill_state_i;
  assign l1_if.inv_all    = (state_q == ST_INV);
  assign l2_if.inv_all    = (state_q == ST_INV);
  assign l1_if.scan_idx   = scan_idx[L1_IDX_W-1:0];
  assign l2_if.scan_idx   = scan_idx;

  assign any_hit    = l1_if.lk_hit | l2_if.lk_hit;
  assign any_dirty  = l1_if.lk_dirty | l2_if.lk_dirty;
  assign scan_dirty = scan_lvl ? l2_if.scan_dirty : l1_if.scan_dirty;
  assign scan_line  = scan_lvl ? l2_if.scan_line : l1_if.scan_line;
  assign scan_last  = scan_lvl ? (&scan_idx)
                               : (&scan_idx[L1_IDX_W-1:0]);

  // ----------------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------------
  // hold only honoured between cycles, so a cycle never splits
  always_comb
  begin
    next_state = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (test_mode_o)
          next_state = ST_IDLE;
        else if (bus_hold_req_i)
          next_state = ST_FLOAT;
        else if (wb_pend)
          next_state = ST_WB_LOAD;
        else if (flush_busy_o)
          next_state = ST_SCAN;
      end
      ST_SCAN:
      begin
        if (bus_hold_req_i || wb_pend)
          next_state = ST_IDLE;
        else if (scan_end)
          next_state = ST_INV;
        else if (scan_dirty)
          next_state = ST_WB_LOAD;
      end
      ST_WB_LOAD:
        next_state = ST_WB_BEAT;
      ST_WB_BEAT:
      begin
        if (!xfer_ready_n_i)
          next_state = (addr_o[4:3] == `CSH_BEAT_LAST) ? ST_IDLE
                                                       : ST_WB_LOAD;
      end
      ST_INV:
        next_state = ST_ACK_ADDR;
      ST_ACK_ADDR:
        next_state = ST_ACK_WAIT;
      ST_ACK_WAIT:
      begin
        if (!xfer_ready_n_i)
          next_state = ST_IDLE;
      end
      ST_FLOAT:
        next_state = ST_HELD;
      ST_HELD:
      begin
        if (!bus_hold_req_i)
          next_state = ST_IDLE;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  assign start_wb = (next_state == ST_WB_LOAD) && (state_q != ST_WB_BEAT);
  assign beat_adv = (state_q == ST_WB_BEAT) && !xfer_ready_n_i;
  assign wb_done  = beat_adv && (addr_o[4:3] == `CSH_BEAT_LAST);
  assign ack_done = (state_q == ST_ACK_WAIT) && !xfer_ready_n_i;
  assign scan_adv = ((state_q == ST_SCAN) && (next_state == ST_SCAN)) ||
                    (wb_done && wb_is_flush);
  assign floated  = (next_state == ST_FLOAT) || (next_state == ST_HELD);

  always_comb
  begin
    next_addr = addr_o;
    if (start_wb)
      next_addr = {(state_q == ST_SCAN) ? scan_line : wb_line,
                   `CSH_BEAT_FIRST};
    else if (beat_adv && !wb_done)
      next_addr = {addr_o[31:5], addr_o[4:3] + `CSH_BEAT_STEP};
    else if (next_state == ST_ACK_ADDR)
      next_addr = `CSH_ADDR_ZERO;
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      state_q <= ST_IDLE;
    else
      state_q <= next_state;
  end

  // ----------------------------------------------------------------------
  // flush walk
  // ----------------------------------------------------------------------
  // a new request while busy merges into the running flush
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      flush_busy_o <= 1'b0;
    else if (flush_req)
      flush_busy_o <= 1'b1;
    else if (ack_done)
      flush_busy_o <= 1'b0;
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      scan_idx <= '0;
      scan_lvl <= 1'b0;
      scan_end <= 1'b0;
    end
    else if (flush_req && !flush_busy_o)
    begin
      scan_idx <= '0;
      scan_lvl <= 1'b0;
      scan_end <= 1'b0;
    end
    else if (scan_adv)
    begin
      scan_idx <= scan_last ? '0 : scan_idx + 1'b1;
      scan_lvl <= scan_lvl | scan_last;
      scan_end <= scan_lvl && scan_last;
    end
  end

  // ----------------------------------------------------------------------
  // inquire response
  // ----------------------------------------------------------------------
  // no new lookup while a snoop writeback waits: one line buffered
  assign snoop_go = snoop_pend && !wb_pend &&
                    ((state_q == ST_IDLE) || (state_q == ST_SCAN) ||
                     (state_q == ST_FLOAT) || (state_q == ST_HELD));

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      snoop_pend <= 1'b0;
    else if (!snoop_addr_strobe_n_i)
      snoop_pend <= 1'b1;
    else if (snoop_go)
      snoop_pend <= 1'b0;
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      snoop_line <= '0;
    else if (!snoop_addr_strobe_n_i)
      snoop_line <= addr_i[31:5];
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      snoop_hit_n_o         <= 1'b1;
      snoop_dirty_match_n_o <= 1'b1;
    end
    else if (snoop_go)
    begin
      snoop_hit_n_o         <= ~any_hit;
      snoop_dirty_match_n_o <= ~any_dirty;
    end
    else if (wb_done && !wb_is_flush)
      snoop_dirty_match_n_o <= 1'b1;
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wb_pend <= 1'b0;
      wb_line <= '0;
      wb_l2   <= 1'b0;
    end
    else if (snoop_go && any_dirty)
    begin
      wb_pend <= 1'b1;
      wb_line <= snoop_line;
      wb_l2   <= ~l1_if.lk_dirty;
    end
    else if (wb_done && !wb_is_flush)
      wb_pend <= 1'b0;
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wb_is_flush <= 1'b0;
      wb_src_l2_o <= 1'b0;
    end
    else if (start_wb)
    begin
      wb_is_flush <= (state_q == ST_SCAN);
      wb_src_l2_o <= (state_q == ST_SCAN) ? scan_lvl : wb_l2;
    end
  end

  // ----------------------------------------------------------------------
  // bus ownership
  // ----------------------------------------------------------------------
  // enables drop one edge before the acknowledge rises
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      bus_oe_o            <= 1'b0;
      data_oe_o           <= 1'b0;
      bus_surrender_ack_o <= 1'b0;
    end
    else
    begin
      bus_oe_o            <= armed && !test_mode_o && !floated;
      data_oe_o           <= armed && !test_mode_o && !floated &&
                             ((next_state == ST_WB_LOAD) ||
                              (next_state == ST_WB_BEAT));
      bus_surrender_ack_o <= (next_state == ST_HELD);
    end
  end

  // ----------------------------------------------------------------------
  // bus outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      addr_o                     <= `CSH_ADDR_ZERO;
      addr_parity_o              <= 1'b0;
      byte_lane_en_n_o           <= `CSH_BLE_NONE;
      cycle_addr_strobe_n_o      <= 1'b1;
      cycle_addr_strobe_copy_n_o <= 1'b1;
      mem_io_o                   <= 1'b0;
      data_code_o                <= 1'b0;
      write_read_o               <= 1'b0;
      cache_burst_n_o            <= 1'b1;
    end
    else
    begin
      addr_o                     <= next_addr;
      addr_parity_o              <= ^next_addr;
      cycle_addr_strobe_n_o      <= ~(start_wb || (state_q == ST_INV));
      cycle_addr_strobe_copy_n_o <= ~(start_wb || (state_q == ST_INV));
      if (start_wb)
      begin
        byte_lane_en_n_o <= `CSH_BLE_ALL;
        mem_io_o         <= 1'b1;
        data_code_o      <= 1'b1;
        write_read_o     <= 1'b1;
        cache_burst_n_o  <= 1'b0;
      end
      else if (state_q == ST_INV)
      begin
        byte_lane_en_n_o <= `CSH_FLUSH_ACK_BE;
        mem_io_o         <= 1'b0;
        data_code_o      <= 1'b0;
        write_read_o     <= 1'b1;
        cache_burst_n_o  <= 1'b1;
      end
    end
  end

  // never locked, never uncached: these cycles are writebacks or the flush acknowledge
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      lock_n_o            <= 1'b1;
      page_uncached_o     <= 1'b0;
      page_writethrough_o <= 1'b0;
      split_cycle_o       <= 1'b0;
    end
    else
    begin
      lock_n_o            <= 1'b1;
      page_uncached_o     <= 1'b0;
      page_writethrough_o <= 1'b0;
      split_cycle_o       <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      data_o             <= `CSH_DATA_ZERO;
      data_byte_parity_o <= 8'h00;
    end
    else if (state_q == ST_WB_LOAD)
    begin
      data_o             <= wb_data_i;
      data_byte_parity_o <= byte_par(wb_data_i);
    end
  end

endmodule : csh_ctrl

// ==== csh_ctrl_chk.sv ====
// Purpose: port checks on csh_ctrl
// Assumes: bound to csh_ctrl
// Notes:   one clock domain
`timescale 1ns/1ns
`include "csh_defines.svh"
module csh_ctrl_chk
(
  input wire logic       mclk_i,
  input wire logic       resetn_i,
  input wire logic       flush_n_i,
  input wire logic       bus_hold_req_i,
  input wire logic       snoop_dirty_match_n_o,
  input wire logic       bus_surrender_ack_o,
  input wire logic       test_mode_o,
  input wire logic       bus_oe_o,
  input wire logic       data_oe_o,
  input wire logic [7:0] byte_lane_en_n_o,
  input wire logic       cycle_addr_strobe_n_o,
  input wire logic       mem_io_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  property p_flt;
    bus_surrender_ack_o |-> !bus_oe_o && !data_oe_o;
  endproperty
  a_flt: assert property (p_flt) else $error("ack with bus driven");
  property p_ord;
    $rose(bus_surrender_ack_o) |-> !$past(bus_oe_o) && !$past(data_oe_o);
  endproperty
  a_ord: assert property (p_ord) else $error("ack before float");
  property p_keep;
    bus_surrender_ack_o && bus_hold_req_i |=> bus_surrender_ack_o;
  endproperty
  a_keep: assert property (p_keep) else $error("ack dropped");
  property p_rel;
    bus_surrender_ack_o && !bus_hold_req_i
      |=> !bus_surrender_ack_o && bus_oe_o;
  endproperty
  a_rel: assert property (p_rel) else $error("no bus resume");
  // ack must wait for the running cycle to end
  property p_fin;
    bus_hold_req_i && data_oe_o |=> !bus_surrender_ack_o;
  endproperty
  a_fin: assert property (p_fin) else $error("ack mid cycle");
  property p_strap;
    $rose(resetn_i) |=> test_mode_o == !$past(flush_n_i);
  endproperty
  a_strap: assert property (p_strap) else $error("strap lost");
  property p_wb;
    $fell(snoop_dirty_match_n_o) && !bus_hold_req_i
      |-> ##[0:300] !cycle_addr_strobe_n_o && mem_io_o;
  endproperty
  a_wb: assert property (p_wb) else $error("no writeback");
  property p_ack;
    bus_oe_o && !cycle_addr_strobe_n_o && !mem_io_o
      |-> byte_lane_en_n_o == `CSH_FLUSH_ACK_BE;
  endproperty
  a_ack: assert property (p_ack) else $error("bad ack cycle");
endmodule : csh_ctrl_chk

bind csh_ctrl csh_ctrl_chk i_csh_ctrl_chk (.*);

// ==== csh_sys_model.sv ====
// Purpose: system side ready responder
// Assumes: one bus cycle at a time
// Notes:   slow_i adds wait states per beat
`timescale 1ns/1ns
module csh_sys_model
(
  input  wire logic       mclk_i,
  input  wire logic       resetn_i,
  input  wire logic [1:0] slow_i,
  input  wire logic       strobe_n_i,
  input  wire logic [1:0] beat_i,
  input  wire logic       data_oe_i,
  input  wire logic       flush_busy_i,
  output logic            xfer_ready_n_o
);
  logic       busy, oe_q, fb_q;
  logic [1:0] cnt, beat_q;
  // beat change restarts the wait, so each beat sees slow_i waits
  always_ff @(posedge mclk_i or negedge resetn_i)
    if (!resetn_i)
      {busy, oe_q, fb_q, cnt, beat_q} <= 7'h0;
    else
    begin
      {oe_q, fb_q, beat_q} <= {data_oe_i, flush_busy_i, beat_i};
      if (!strobe_n_i)
        busy <= 1'h1;
      else if ((oe_q && !data_oe_i) || (fb_q && !flush_busy_i))
        busy <= 1'h0;
      if (!strobe_n_i || beat_q != beat_i)
        cnt <= 2'h0;
      else if (cnt != slow_i)
        cnt <= cnt + 2'h1;
    end
  assign xfer_ready_n_o = !(busy && cnt == slow_i);
endmodule : csh_sys_model

// ==== testbench.sv ====
// Purpose: self-checking bench for csh_ctrl
// Assumes: small cache sizes, lines placed by fill
// Notes:   monitor reads pre-edge values
`timescale 1ns/1ns
`include "csh_defines.svh"
module testbench;
  import csh_pkg::*;
  logic [31:3] addr_i = 29'h0, addr_o;
  logic [63:0] wb_data_i = 64'h0f1e_2d3c_4b5a_6970, data_o;
  logic [26:0] fill_line_i = 27'h0, wb_line;
  logic [7:0]  byte_lane_en_n_o, data_byte_parity_o, ack_be;
  logic [1:0]  slow = 2'h0;
  csh_line_e   fill_state_i = LINE_INV;
  logic        mclk_i = 1'h0, resetn_i = 1'h0, flush_n_i = 1'h1;
  logic        snoop_addr_strobe_n_i = 1'h1, snoop_kill_line_i = 1'h0;
  logic        bus_hold_req_i = 1'h0, fill_l1_i = 1'h0, fill_l2_i = 1'h0;
  logic        xfer_ready_n_i, snoop_hit_n_o, snoop_dirty_match_n_o;
  logic        bus_surrender_ack_o, test_mode_o, flush_busy_o, wb_src_l2_o;
  logic        bus_oe_o, data_oe_o, addr_parity_o, cycle_addr_strobe_n_o;
  logic        cycle_addr_strobe_copy_n_o, mem_io_o, data_code_o;
  logic        write_read_o, cache_burst_n_o, lock_n_o, page_uncached_o;
  logic        page_writethrough_o, split_cycle_o;
  int          num_errors = 0, checks = 0, cyc = 0, n_wb = 0;

  csh_ctrl #(.L1_IDX_W(2), .L2_IDX_W(3)) i_csh_ctrl (.*);
  csh_sys_model i_csh_sys_model (.mclk_i, .resetn_i, .slow_i(slow),
    .strobe_n_i(cycle_addr_strobe_n_o), .beat_i(addr_o[4:3]),
    .data_oe_i(data_oe_o), .flush_busy_i(flush_busy_o),
    .xfer_ready_n_o(xfer_ready_n_i));

  always #4 mclk_i = ~mclk_i;

  always @(posedge mclk_i)
  begin
    cyc++;
    if (!cycle_addr_strobe_n_o && mem_io_o)
    begin
      n_wb++;
      wb_line = addr_o[31:5];
    end
    if (!cycle_addr_strobe_n_o && !mem_io_o)
      ack_be = byte_lane_en_n_o;
    if (cyc == 20000)
    begin
      num_errors++;
      conclude();
    end
  end

  task automatic tk(input int n = 1);
    repeat (n) @(posedge mclk_i);
  endtask : tk

  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  task automatic do_reset(input logic strap);
    resetn_i <= 1'h0;
    flush_n_i <= strap;
    tk(20);
    resetn_i <= 1'h1;
    tk(3);
    flush_n_i <= 1'h1;
    @(negedge mclk_i);
    chk("strap", {test_mode_o, bus_oe_o}, {!strap, strap});
    tk();
  endtask : do_reset

  task automatic fill(input logic l2, logic [26:0] ln, csh_line_e st);
    {fill_l1_i, fill_l2_i} <= {!l2, l2};
    fill_line_i <= ln;
    fill_state_i <= st;
    tk();
    {fill_l1_i, fill_l2_i} <= 2'h0;
    tk();
  endtask : fill

  task automatic snoop(input logic [26:0] ln, logic kill, hit, dirty);
    snoop_addr_strobe_n_i <= 1'h0;
    addr_i <= {ln, 2'h0};
    snoop_kill_line_i <= kill;
    tk();
    snoop_addr_strobe_n_i <= 1'h1;
    tk(2);
    @(negedge mclk_i);
    chk("hit_n", snoop_hit_n_o, !hit);
    chk("dirty_n", snoop_dirty_match_n_o, !dirty);
    tk();
  endtask : snoop

  task automatic wb_done(input int n0, logic [26:0] ln, logic src);
    repeat (300)
    begin
      @(negedge mclk_i);
      if (n_wb == n0 + 1 && !data_oe_o)
        break;
    end
    chk("wb_line", wb_line, ln);
    chk("dirty_end", snoop_dirty_match_n_o, 1'h1);
    chk("wb_attr", {wb_src_l2_o, data_byte_parity_o, data_o[7:0],
      addr_parity_o, write_read_o, data_code_o, cache_burst_n_o},
      {src, 20'h0170e});
    tk();
  endtask : wb_done

  task automatic t_snoop();
    int n0;
    slow <= 2'h2;
    fill(1'h0, 27'h10, LINE_MOD);
    fill(1'h1, 27'h21, LINE_EXC);
    snoop(27'h33, 1'h0, 1'h0, 1'h0);
    snoop(27'h21, 1'h1, 1'h1, 1'h0);
    snoop(27'h21, 1'h0, 1'h0, 1'h0);
    n0 = n_wb;
    snoop(27'h10, 1'h0, 1'h1, 1'h1);
    wb_done(n0, 27'h10, 1'h0);
    snoop(27'h10, 1'h0, 1'h1, 1'h0);
  endtask : t_snoop

  task automatic t_hold();
    int n0;
    slow <= 2'h3;
    fill(1'h1, 27'h45, LINE_MOD);
    n0 = n_wb;
    snoop(27'h45, 1'h1, 1'h1, 1'h1);
    bus_hold_req_i <= 1'h1;
    tk();
    @(negedge mclk_i);
    chk("early_ack", {bus_surrender_ack_o, data_oe_o}, 2'h1);
    wb_done(n0, 27'h45, 1'h1);
    tk(2);
    @(negedge mclk_i);
    chk("held", {bus_surrender_ack_o, bus_oe_o, data_oe_o}, 3'h4);
    tk();
    snoop(27'h45, 1'h0, 1'h0, 1'h0);
    @(negedge mclk_i);
    chk("held_on", bus_surrender_ack_o, 1'h1);
    tk();
    bus_hold_req_i <= 1'h0;
    tk(2);
    @(negedge mclk_i);
    chk("resume", {bus_surrender_ack_o, bus_oe_o}, 2'h1);
    tk();
    snoop(27'h45, 1'h0, 1'h0, 1'h0);
  endtask : t_hold

  task automatic t_flush();
    int n0;
    slow <= 2'h0;
    fill(1'h0, 27'h06, LINE_MOD);
    fill(1'h1, 27'h0f, LINE_MOD);
    n0 = n_wb;
    flush_n_i <= 1'h0;
    tk();
    flush_n_i <= 1'h1;
    tk(2);
    repeat (400)
    begin
      @(negedge mclk_i);
      if (!flush_busy_o)
        break;
    end
    chk("flush_end", flush_busy_o, 1'h0);
    chk("flush_wb", n_wb - n0, 2);
    chk("ack_be", ack_be, `CSH_FLUSH_ACK_BE);
    tk();
    snoop(27'h06, 1'h0, 1'h0, 1'h0);
    snoop(27'h0f, 1'h0, 1'h0, 1'h0);
    snoop(27'h10, 1'h0, 1'h0, 1'h0);
  endtask : t_flush

  initial
  begin
    do_reset(1'h0);
    do_reset(1'h1);
    t_snoop();
    t_hold();
    t_flush();
    conclude();
  end
endmodule : testbench
